// ### ipce_regs.vh
// Register offsets, field positions, reset values for the port C irq block
`ifndef IPCE_REGS_VH
`define IPCE_REGS_VH
`define IPCE_IDX_REQ      12'h0fc6
`define IPCE_IDX_ENH      12'h0fc7
`define IPCE_IDX_ENL      12'h0fc8
`define IPCE_IDX_EDGE     12'h0fcd
`define IPCE_IDX_SSEL     12'h0fce
`define IPCE_IDX_CTL      12'h0fcf
`define IPCE_IDX_EVST     12'h0fd0
`define IPCE_IDX_EVMASK   12'h0fd1
`define IPCE_IDX_PA_REQ   12'h0fd2
`define IPCE_RST_BYTE     8'h00
`define IPCE_SSEL_BIT     6
`define IPCE_CTL_EN_BIT   7
`define IPCE_PORTC_MASK   8'h0f
`define IPCE_SSEL_MASK    8'h40
`define IPCE_CTL_MASK     8'h80
`endif

// ### ipce_sync_edge.v
// Two-stage synchroniser with selectable edge detector
`default_nettype none
module ipce_sync_edge (
  // Clock and reset
  input  wire ref_clk,
  input  wire reset_n,
  // Pin and control
  input  wire pin_in,
  input  wire rise_sel,
  // Detected edge and synchronised level
  output wire edge_pulse,
  output wire level_out
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out  = sync_ff;
  assign edge_pulse = rise_sel ? (sync_ff & ~prev_ff)
                               : (~sync_ff & prev_ff);
endmodule
`default_nettype wire

// ### ipce_edge_mux.v
// Edge detector on an already synchronised, selectable source
`default_nettype none
module ipce_edge_mux (
  // Clock and reset
  input  wire ref_clk,
  input  wire reset_n,
  // Sources, both synchronised
  input  wire src_a,
  input  wire src_b,
  input  wire sel_b,
  input  wire rise_sel,
  // Detected edge
  output wire edge_pulse
);
  reg  prev_ff;
  wire cur;

  // The old sample belongs to the old source, so a switch can fire
  assign cur = sel_b ? src_b : src_a;

  always @(posedge ref_clk) begin
    if (!reset_n)
      prev_ff <= 1'b0;
    else
      prev_ff <= cur;
  end

  assign edge_pulse = rise_sel ? (cur & ~prev_ff) : (~cur & prev_ff);
endmodule
`default_nettype wire

// ### ipce_irq_top.v
// Port C enables, edge select, shared select and master enable block
//
// The AHB-Lite register port was left to the implementer.
`default_nettype none
`include "ipce_regs.vh"
module ipce_irq_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Request pins
  input  wire [3:0]  port_c_pins,
  input  wire [7:0]  port_ad_pins,
  input  wire        comparator_out,
  // CPU side
  input  wire        allow_interrupts_instr,
  input  wire        return_from_handler_instr,
  input  wire        block_interrupts_instr,
  input  wire        cpu_irq_ack,
  output wire [3:0]  portc_irq_req,
  output wire [7:0]  portc_prio_flat,
  output wire        global_irq_allow,
  // Event interrupt
  output wire        irq_out
);
  // Pin counts of the two request groups
  localparam PC_PINS = 4;
  localparam AD_PINS = 8;

  reg  [7:0]  port_c_irq_enable_high_ff;
  reg  [7:0]  port_c_irq_enable_low_ff;
  reg  [7:0]  irq_edge_polarity_ff;
  reg  [7:0]  shared_irq_source_select_ff;
  reg         global_irq_allow_ff;
  reg  [3:0]  portc_pin_pending_ff;
  reg  [7:0]  pa_pending_ff;
  reg  [7:0]  ev_status_ff;
  reg  [7:0]  ev_mask_ff;
  reg  [31:0] hrdata_ff;
  reg         wr_pend_ff;
  reg  [11:0] wr_idx_ff;
  reg  [7:0]  nxt_rd;
  // Next values, settled before each clock edge
  reg  [7:0]  nxt_enh;
  reg  [7:0]  nxt_enl;
  reg  [7:0]  nxt_edge;
  reg  [7:0]  nxt_ssel;
  reg  [7:0]  nxt_evmask;
  reg         nxt_allow;
  reg  [3:0]  nxt_pc_pend;
  reg  [7:0]  nxt_pa_pend;
  reg  [7:0]  nxt_ev_status;
  wire        addr_phase;
  wire [11:0] a_idx;
  wire [11:0] w_idx;
  wire [7:0]  wdata;
  reg         wr_enh;
  reg         wr_enl;
  reg         wr_edge;
  reg         wr_ssel;
  reg         wr_ctl;
  reg         wr_req;
  reg         wr_pa;
  reg         wr_evst;
  reg         wr_evmask;
  wire [3:0]  pc_edge;
  wire [7:0]  pad_edge;
  wire [7:0]  pad_level;
  wire        cmp_level;
  wire        pin6_edge;
  wire [7:0]  pa_hit;
  wire [7:0]  ev_set;
  wire [1:0]  prio [0:3];

  assign addr_phase = hsel & hready & htrans[1];
  assign a_idx      = haddr[13:2];
  assign w_idx      = wr_idx_ff;
  assign wdata      = hwdata[7:0];

  // Write data arrives a cycle after the address, so latch the target
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 12'h000;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx_ff <= a_idx;
      end
    end
  end

  // One strobe per register, live only in the write data phase
  always @* begin
    wr_enh    = 1'b0;
    wr_enl    = 1'b0;
    wr_edge   = 1'b0;
    wr_ssel   = 1'b0;
    wr_ctl    = 1'b0;
    wr_req    = 1'b0;
    wr_pa     = 1'b0;
    wr_evst   = 1'b0;
    wr_evmask = 1'b0;
    case (w_idx)
      `IPCE_IDX_ENH:    wr_enh    = wr_pend_ff;
      `IPCE_IDX_ENL:    wr_enl    = wr_pend_ff;
      `IPCE_IDX_EDGE:   wr_edge   = wr_pend_ff;
      `IPCE_IDX_SSEL:   wr_ssel   = wr_pend_ff;
      `IPCE_IDX_CTL:    wr_ctl    = wr_pend_ff;
      `IPCE_IDX_REQ:    wr_req    = wr_pend_ff;
      `IPCE_IDX_PA_REQ: wr_pa     = wr_pend_ff;
      `IPCE_IDX_EVST:   wr_evst   = wr_pend_ff;
      `IPCE_IDX_EVMASK: wr_evmask = wr_pend_ff;
      default:          wr_enh    = 1'b0;
    endcase
  end

  // Next values of the configuration registers
  always @* begin
    nxt_enh    = port_c_irq_enable_high_ff;
    nxt_enl    = port_c_irq_enable_low_ff;
    nxt_edge   = irq_edge_polarity_ff;
    nxt_ssel   = shared_irq_source_select_ff;
    nxt_evmask = ev_mask_ff;
    if (wr_enh) begin
      nxt_enh = wdata & `IPCE_PORTC_MASK;
    end
    if (wr_enl) begin
      nxt_enl = wdata & `IPCE_PORTC_MASK;
    end
    if (wr_edge) begin
      nxt_edge = wdata;
    end
    if (wr_ssel) begin
      nxt_ssel = wdata & `IPCE_SSEL_MASK;
    end
    if (wr_evmask) begin
      nxt_evmask = wdata;
    end
  end

  // Configuration registers
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      port_c_irq_enable_high_ff   <= `IPCE_RST_BYTE;
      port_c_irq_enable_low_ff    <= `IPCE_RST_BYTE;
      irq_edge_polarity_ff        <= `IPCE_RST_BYTE;
      shared_irq_source_select_ff <= `IPCE_RST_BYTE;
      ev_mask_ff                  <= `IPCE_RST_BYTE;
    end else begin
      port_c_irq_enable_high_ff   <= nxt_enh;
      port_c_irq_enable_low_ff    <= nxt_enl;
      irq_edge_polarity_ff        <= nxt_edge;
      shared_irq_source_select_ff <= nxt_ssel;
      ev_mask_ff                  <= nxt_evmask;
    end
  end

  // Master enable: disable and ack outrank enable and return, which outrank a control write,
  // so an acknowledge never leaves the enable standing
  always @* begin
    nxt_allow = global_irq_allow_ff;
    if (block_interrupts_instr | cpu_irq_ack) begin
      nxt_allow = 1'b0;
    end else if (allow_interrupts_instr | return_from_handler_instr) begin
      nxt_allow = 1'b1;
    end else if (wr_ctl) begin
      nxt_allow = wdata[`IPCE_CTL_EN_BIT];
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      global_irq_allow_ff <= 1'b0;
    end else begin
      global_irq_allow_ff <= nxt_allow;
    end
  end

  // Port C pins: falling edge fixed, since no polarity control exists
  genvar gi;
  generate
    for (gi = 0; gi < PC_PINS; gi = gi + 1) begin : g_pc
      ipce_sync_edge u_pc (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .pin_in     (port_c_pins[gi]),
        .rise_sel   (1'b0),
        .edge_pulse (pc_edge[gi]),
        .level_out  ()
      );
      assign prio[gi] = {port_c_irq_enable_high_ff[gi],
                         port_c_irq_enable_low_ff[gi]};
      assign portc_prio_flat[2*gi+1:2*gi] = prio[gi];
    end
    for (gi = 0; gi < AD_PINS; gi = gi + 1) begin : g_pad
      ipce_sync_edge u_pad (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .pin_in     (port_ad_pins[gi]),
        .rise_sel   (irq_edge_polarity_ff[gi]),
        .edge_pulse (pad_edge[gi]),
        .level_out  (pad_level[gi])
      );
    end
  endgenerate

  // Only the synchronised level is used; pin6 edges come from the mux
  ipce_sync_edge u_cmp (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .pin_in     (comparator_out),
    .rise_sel   (1'b0),
    .edge_pulse (),
    .level_out  (cmp_level)
  );

  // Edge taken after the mux, so a source switch may fire by itself
  ipce_edge_mux u_pin6 (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .src_a      (pad_level[6]),
    .src_b      (cmp_level),
    .sel_b      (shared_irq_source_select_ff[`IPCE_SSEL_BIT]),
    .rise_sel   (irq_edge_polarity_ff[6]),
    .edge_pulse (pin6_edge)
  );

  assign pa_hit = {pad_edge[7], pin6_edge, pad_edge[5:0]};

  // Pending bits: new arrivals win over a software clear
  always @* begin
    nxt_pc_pend = portc_pin_pending_ff;
    nxt_pa_pend = pa_pending_ff;
    if (wr_req) begin
      nxt_pc_pend = wdata[3:0];
    end
    if (wr_pa) begin
      nxt_pa_pend = wdata;
    end
    nxt_pc_pend = nxt_pc_pend | pc_edge;
    nxt_pa_pend = nxt_pa_pend | pa_hit;
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      portc_pin_pending_ff <= 4'h0;
      pa_pending_ff        <= 8'h00;
    end else begin
      portc_pin_pending_ff <= nxt_pc_pend;
      pa_pending_ff        <= nxt_pa_pend;
    end
  end

  // Vectored requests only while the master enable is on
  generate
    for (gi = 0; gi < PC_PINS; gi = gi + 1) begin : g_req
      assign portc_irq_req[gi] = global_irq_allow_ff
                                 & portc_pin_pending_ff[gi]
                                 & (prio[gi] != 2'b00);
    end
  endgenerate

  assign global_irq_allow = global_irq_allow_ff;

  // Event status: bits 3:0 port C arrivals, 7:4 pins 4..7 of A/D, with bit 6 taken from the shared pin6 mux
  assign ev_set = {pa_hit[7:4], pc_edge};

  // Write one to clear; an event in the same cycle keeps its bit,
  // so a clear can never swallow a fresh arrival
  always @* begin
    nxt_ev_status = ev_status_ff;
    if (wr_evst) begin
      nxt_ev_status = ev_status_ff & ~wdata;
    end
    nxt_ev_status = nxt_ev_status | ev_set;
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ev_status_ff <= 8'h00;
    end else begin
      ev_status_ff <= nxt_ev_status;
    end
  end

  assign irq_out = |(ev_status_ff & ev_mask_ff);

  // Read mux
  always @* begin
    case (a_idx)
      `IPCE_IDX_REQ:    nxt_rd = {4'h0, portc_pin_pending_ff};
      `IPCE_IDX_ENH:    nxt_rd = port_c_irq_enable_high_ff;
      `IPCE_IDX_ENL:    nxt_rd = port_c_irq_enable_low_ff;
      `IPCE_IDX_EDGE:   nxt_rd = irq_edge_polarity_ff;
      `IPCE_IDX_SSEL:   nxt_rd = shared_irq_source_select_ff;
      `IPCE_IDX_CTL:    nxt_rd = {global_irq_allow_ff, 7'h00};
      `IPCE_IDX_EVST:   nxt_rd = ev_status_ff;
      `IPCE_IDX_EVMASK: nxt_rd = ev_mask_ff;
      `IPCE_IDX_PA_REQ: nxt_rd = pa_pending_ff;
      default:          nxt_rd = 8'h00;
    endcase
  end

  // Read data is taken in the address phase and stands all data phase
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata_ff <= {24'h00_0000, nxt_rd};
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule
`default_nettype wire

// ### ipce_irq_chk.sv
// Assertion checker on the ports of the port C irq block
`default_nettype none
module ipce_irq_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins
  input wire logic [3:0]  port_c_pins,
  input wire logic [7:0]  port_ad_pins,
  input wire logic        comparator_out,
  // CPU side
  input wire logic        allow_interrupts_instr,
  input wire logic        return_from_handler_instr,
  input wire logic        block_interrupts_instr,
  input wire logic        cpu_irq_ack,
  input wire logic [3:0]  portc_irq_req,
  input wire logic [7:0]  portc_prio_flat,
  input wire logic        global_irq_allow,
  input wire logic        irq_out
);
  logic       wr_ff;
  logic [3:0] en_c;
  logic       set_c;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Marks a write data phase, the only cycle a register may take data
  always_ff @(posedge ref_clk) begin
    wr_ff <= hsel & hready & htrans[1] & hwrite;
  end
  assign en_c = {|portc_prio_flat[7:6], |portc_prio_flat[5:4],
                 |portc_prio_flat[3:2], |portc_prio_flat[1:0]};
  assign set_c = allow_interrupts_instr | return_from_handler_instr;
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_di_clear: assert property (block_interrupts_instr |=>
    !global_irq_allow) else $error("allow kept after disable");
  chk_ack_clear: assert property (cpu_irq_ack |=>
    !global_irq_allow) else $error("allow kept after ack");
  chk_ei_set: assert property (set_c && !block_interrupts_instr
    && !cpu_irq_ack |=> global_irq_allow) else $error("allow not set");
  chk_req_gated: assert property (|portc_irq_req |->
    global_irq_allow) else $error("request while blocked");
  chk_req_prio: assert property ((portc_irq_req & ~en_c) == 4'h0)
    else $error("request from disabled pin");
  chk_allow_cause: assert property ($changed(global_irq_allow) |->
    $past(wr_ff | set_c | block_interrupts_instr | cpu_irq_ack))
    else $error("allow changed without cause");
  chk_prio_cause: assert property ($changed(portc_prio_flat) |->
    $past(wr_ff)) else $error("priority changed without write");
  chk_req_after_ack: assert property (cpu_irq_ack |=>
    portc_irq_req == 4'h0) else $error("request after ack");
  chk_rdata_pad: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  cover property (cpu_irq_ack);
  cover property (|portc_irq_req);
  cover property (irq_out);
  cover property ($rose(global_irq_allow));
endmodule
bind ipce_irq_top ipce_irq_chk u_chk (.*);
`default_nettype wire

// ### ipce_cpu_model.sv
// CPU core model: instruction pulses and interrupt acknowledge
`default_nettype none
module ipce_cpu_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Bench commands: 1 enable, 2 return, 3 disable; ack_en low = no ack
  input  wire logic [1:0] op_cmd,
  input  wire logic       ack_en,
  // From the block
  input  wire logic [3:0] portc_irq_req,
  input  wire logic       global_irq_allow,
  // To the block
  output logic            ei_pulse,
  output logic            return_from_handler_instr_pulse,
  output logic            di_pulse,
  output logic            ack_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk) begin
    ei_pulse <= reset_n && op_cmd == 2'h1;
    return_from_handler_instr_pulse <= reset_n && op_cmd == 2'h2;
    di_pulse <= reset_n && op_cmd == 2'h3;
    // One ack per request; allow drops a cycle after it
    ack_pulse <= reset_n && ack_en && !ack_pulse && |portc_irq_req
                 && global_irq_allow;
  end
endmodule
`default_nettype wire

// ### ipce_irq_top_test.sv
// Self-checking bench for the port C irq block
`default_nettype none
`include "ipce_regs.vh"
module ipce_irq_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] RQ = `IPCE_IDX_REQ, EH = `IPCE_IDX_ENH;
  localparam logic [11:0] EL = `IPCE_IDX_ENL, ED = `IPCE_IDX_EDGE;
  localparam logic [11:0] SS = `IPCE_IDX_SSEL, CT = `IPCE_IDX_CTL;
  localparam logic [11:0] EV = `IPCE_IDX_EVST, EM = `IPCE_IDX_EVMASK;
  localparam logic [11:0] PA = `IPCE_IDX_PA_REQ;
  logic        ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0;
  logic        hwrite = 1'b0, hready, hreadyout, hresp;
  logic        comparator_out = 1'b0, ack_en = 1'b0, cpu_irq_ack;
  logic        allow_interrupts_instr, return_from_handler_instr;
  logic        block_interrupts_instr, global_irq_allow, irq_out;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, op_cmd = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  port_c_pins = 4'hf, portc_irq_req, k;
  logic [7:0]  port_ad_pins = 8'h00, portc_prio_flat, q, p, hi, lo;
  logic [11:0] idx [7] = '{RQ, EH, EL, ED, SS, CT, 12'h0fc9};
  int          errors = 0, n_compared = 0;
  ipce_irq_top dut (.*);
  assign hready = hreadyout;
  ipce_cpu_model cpu (.ref_clk, .reset_n, .op_cmd, .ack_en,
    .portc_irq_req, .global_irq_allow, .ei_pulse(allow_interrupts_instr),
    .return_from_handler_instr_pulse(return_from_handler_instr),
    .di_pulse(block_interrupts_instr), .ack_pulse(cpu_irq_ack));
  always #2 ref_clk = ~ref_clk;
  task automatic ck(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Wait for hready at a rising edge, never longer than 20 cycles
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      errors++;
      stop_test;
    end
  endtask
  task automatic x(input logic [11:0] a, input logic w, logic [7:0] d);
    haddr <= {18'h0_0000, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    rdy;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    rdy;
    q = hrdata[7:0];
  endtask
  task automatic settle;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic op(input logic [1:0] c);
    op_cmd <= c;
    @(posedge ref_clk);
    op_cmd <= 2'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  function automatic logic [7:0] flat(input logic [3:0] h, l);
    for (int i = 0; i < 4; i++) flat[2*i +: 2] = {h[i], l[i]};
  endfunction
  initial begin
    p = 8'($urandom(85));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      x(idx[i], 1'b0, 8'h00);
      ck("reset value", 8'h00, q);
    end
    $display("test reset done");
    repeat (8) begin
      hi = 8'($urandom);
      lo = 8'($urandom);
      x(EH, 1'b1, hi);
      x(EL, 1'b1, lo);
      x(EH, 1'b0, 8'h00);
      ck("enable high", hi & 8'h0f, q);
      x(EL, 1'b0, 8'h00);
      ck("enable low", lo & 8'h0f, q);
      ck("priority", flat(hi[3:0], lo[3:0]), portc_prio_flat);
    end
    $display("test enables done");
    x(CT, 1'b1, 8'hff);
    x(CT, 1'b0, 8'h00);
    ck("control", 8'h80, q);
    ck("write set", 8'h01, 8'(global_irq_allow));
    op(2'h3);
    ck("disable", 8'h00, 8'(global_irq_allow));
    op(2'h2);
    ck("return", 8'h01, 8'(global_irq_allow));
    x(CT, 1'b1, 8'h00);
    x(CT, 1'b0, 8'h00);
    ck("write clear", 8'h00, q);
    $display("test master enable done");
    k = 4'h1 << ($urandom % 4);
    x(EH, 1'b1, {4'h0, k});
    x(EL, 1'b1, 8'h00);
    port_c_pins <= 4'h0;
    settle;
    x(RQ, 1'b0, 8'h00);
    ck("pending", 8'h0f, q);
    ck("polled", 8'h00, {4'h0, portc_irq_req});
    op(2'h1);
    ck("forwarded", {4'h0, k}, {4'h0, portc_irq_req});
    ack_en <= 1'b1;
    settle;
    ack_en <= 1'b0;
    ck("ack", 8'h00, 8'(global_irq_allow));
    port_c_pins <= 4'hf;
    x(RQ, 1'b1, 8'h00);
    settle;
    x(RQ, 1'b0, 8'h00);
    ck("rise ignored", 8'h00, q);
    $display("test port c done");
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      x(ED, 1'b1, p);
      x(EV, 1'b1, 8'hff);
      x(PA, 1'b1, 8'h00);
      port_ad_pins <= 8'hff;
      settle;
      x(EV, 1'b0, 8'h00);
      ck("status", p & 8'hf0, q);
      ck("masked", 8'h00, 8'(irq_out));
      x(EM, 1'b1, 8'hf0);
      x(PA, 1'b0, 8'h00);
      ck("rising", p, q);
      ck("irq", 8'(|p[7:4]), 8'(irq_out));
      x(EV, 1'b1, 8'hff);
      x(PA, 1'b1, 8'h00);
      ck("irq cleared", 8'h00, 8'(irq_out));
      x(EM, 1'b1, 8'h00);
      port_ad_pins <= 8'h00;
      settle;
      x(PA, 1'b0, 8'h00);
      ck("falling", ~p, q);
    end
    $display("test edges done");
    x(ED, 1'b1, 8'h40);
    x(PA, 1'b1, 8'h00);
    comparator_out <= 1'b1;
    settle;
    x(PA, 1'b0, 8'h00);
    ck("comparator off", 8'h00, q);
    x(EM, 1'b1, 8'h00);
    x(SS, 1'b1, 8'hff);
    x(SS, 1'b0, 8'h00);
    ck("select", 8'h40, q);
    settle;
    x(PA, 1'b0, 8'h00);
    ck("switch edge", 8'h40, q);
    x(PA, 1'b1, 8'h00);
    comparator_out <= 1'b0;
    settle;
    comparator_out <= 1'b1;
    settle;
    x(PA, 1'b0, 8'h00);
    ck("comparator on", 8'h40, q);
    $display("test shared source done");
    op(2'h1);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    ck("reset allow", 8'h00, 8'(global_irq_allow));
    x(SS, 1'b0, 8'h00);
    ck("reset select", 8'h00, q);
    $display("test second reset done");
    stop_test;
  end
endmodule
`default_nettype wire
